// ===== rtl/four_level_strap.sv
// four_level_strap: turns a comparator thermometer code of a strap pin into a level 0..3
// assumes thermo_i comes from three comparators, synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "redriver_cfg.svh"
module four_level_strap #(
    parameter bit CONTINUOUS = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic capture_i,
    input wire logic [2:0] thermo_i,
    output redriver_pkg::strap_level_t level_o
);
    import redriver_pkg::*;

    // highest tripped comparator wins, so a torn code never reads too low
    function automatic strap_level_t thermo_to_level(input logic [2:0] t);
        strap_level_t l;
        l = 2'h0;
        if (t[2]) begin
            l = 2'h3;
        end else if (t[1]) begin
            l = 2'h2;
        end else if (t[0]) begin
            l = 2'h1;
        end
        return l;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= `RD_STRAP_RESET;
        end else if (CONTINUOUS || capture_i) begin
            level_o <= thermo_to_level(thermo_i);
        end
    end

    level_decode_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (capture_i && thermo_i == 3'h7) |=> level_o == 2'h3)
        else $error("floating strap not decoded as level 3");
    level_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!CONTINUOUS && !capture_i) |=> $stable(level_o))
        else $error("sampled strap changed without capture");
endmodule
`default_nettype wire

// ===== rtl/redriver_cfg.svh
// redriver_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes a 100 MHz register clock and a 32-bit classic Wishbone bus
`ifndef REDRIVER_CFG_SVH
`define REDRIVER_CFG_SVH

`define RD_ADR_CTRL 8'h00
`define RD_ADR_DETECT 8'h04
`define RD_ADR_STATUS 8'h08
`define RD_ADR_STRAP 8'h0C

`define RD_CTRL_EQ_LSB 0
`define RD_CTRL_GAIN_LSB 4
`define RD_EQ_RESET 4'h0
`define RD_GAIN_RESET 2'h3
`define RD_STRAP_RESET 2'h3

`define RD_STAT_FOUND_LSB 0
`define RD_STAT_CM50_LSB 4
`define RD_STAT_STANDBY_BIT 8
`define RD_STAT_MODE_LSB 9
`define RD_STAT_DETEN_BIT 11

`define RD_STRAP_EQ_LSB 0
`define RD_STRAP_GAIN_LSB 4
`define RD_STRAP_RXDET_LSB 6
`define RD_STRAP_ADDR01_LSB 8
`define RD_STRAP_ADDR23_LSB 16

`define RD_ADDR_BASE_MODE1 7'h18
`define RD_ADDR_BASE_MODE2 7'h20

`define RD_CLK_MHZ 100
`define RD_POLL_TIME_US 150
`define RD_PROBE_TIME_NS 1000
`define RD_POLL_CYCLES (`RD_POLL_TIME_US * `RD_CLK_MHZ)
`define RD_PROBE_CYCLES ((`RD_PROBE_TIME_NS * `RD_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/redriver_ctrl.sv
// redriver_ctrl: strap decode, control mode, slave addresses and far-end receiver detect
// assumes straps arrive as comparator codes, pins synchronous to clk_i, Wishbone classic bus
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "redriver_cfg.svh"
module redriver_ctrl #(
    parameter int POLL_CYCLES = `RD_POLL_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] eq_strap_low_i,
    input wire logic [2:0] eq_strap_high_i,
    input wire logic [2:0] gain_strap_i,
    input wire logic [2:0] mode_strap_i,
    input wire logic [2:0] addr_strap_i,
    input wire logic [2:0] far_termination_detect_strap_i,
    input wire logic power_down_pin_i,
    input wire logic mux_select_i,
    input wire logic [3:0] far_term_sensed_i,
    output logic [3:0] eq_index_o,
    output redriver_pkg::strap_level_t flat_gain_o,
    output redriver_pkg::strap_level_t ctrl_mode_o,
    output logic slave_enable_o,
    output logic [6:0] slave_addr_ch01_o,
    output logic [6:0] slave_addr_ch23_o,
    output logic [3:0] detect_probe_o,
    output logic [3:0] cm_50ohm_o,
    output logic channel_reset_o,
    output logic standby_o
);
    import redriver_pkg::*;

    localparam int PROBE_CYCLES = `RD_PROBE_CYCLES;

    if (POLL_CYCLES < 2 || POLL_CYCLES > 1048575) begin : bad_poll
        $error("POLL_CYCLES out of range for the 20-bit poll counter");
    end

    function automatic logic [6:0] slave_addr(input strap_level_t mode, input strap_level_t adr);
        logic [6:0] base;
        base = (mode == 2'h1) ? `RD_ADDR_BASE_MODE1 : `RD_ADDR_BASE_MODE2;
        return base + {4'h0, adr, 1'b0};
    endfunction

    strap_level_t eq_lo, eq_hi, gain_strap, mode_strap, addr_strap, rxdet_strap;
    logic powered_up;
    logic capture;
    logic pwr_down_q;
    logic sel_q;
    logic [3:0] eq_reg;
    strap_level_t gain_reg;
    logic [3:0] pending;
    logic [3:0] found;
    logic [19:0] cnt;
    det_state_t state;
    logic strap_mode;
    logic slave_mode;
    logic det_en;
    logic wb_req;
    logic wb_wr;
    logic reg_trig_wr;
    logic [3:0] trig;
    logic probe_done;
    logic [3:0] newly_found;
    logic [31:0] rd_data;

    // first clock after reset release stands for power-up
    assign capture = !powered_up;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powered_up <= 1'b0;
        end else begin
            powered_up <= 1'b1;
        end
    end

    four_level_strap #(.CONTINUOUS(1'b0)) u_eq_lo (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(eq_strap_low_i), .level_o(eq_lo)
    );
    four_level_strap #(.CONTINUOUS(1'b0)) u_eq_hi (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(eq_strap_high_i), .level_o(eq_hi)
    );
    four_level_strap #(.CONTINUOUS(1'b0)) u_gain (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(gain_strap_i), .level_o(gain_strap)
    );
    four_level_strap #(.CONTINUOUS(1'b0)) u_addr (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(addr_strap_i), .level_o(addr_strap)
    );
    four_level_strap #(.CONTINUOUS(1'b0)) u_rxdet (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(far_termination_detect_strap_i), .level_o(rxdet_strap)
    );
    // control mode keeps tracking the pin while running
    four_level_strap #(.CONTINUOUS(1'b1)) u_mode (
        .clk_i(clk_i), .rst_i(rst_i), .capture_i(capture),
        .thermo_i(mode_strap_i), .level_o(mode_strap)
    );

    assign strap_mode = (mode_strap == 2'h0);
    assign slave_mode = (mode_strap == 2'h1) || (mode_strap == 2'h2);
    // levels 1 and 2 of the detect strap behave as float: detection stays safe
    assign det_en = (rxdet_strap != 2'h0);

    // bus slave: one wait state, write lands on the edge that sees ack
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign reg_trig_wr = wb_wr && slave_mode && ({wb_adr_i[7:2], 2'h0} == `RD_ADR_DETECT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    always_comb begin
        rd_data = 32'h0;
        case ({wb_adr_i[7:2], 2'h0})
            `RD_ADR_CTRL: begin
                rd_data[`RD_CTRL_EQ_LSB +: 4] = eq_reg;
                rd_data[`RD_CTRL_GAIN_LSB +: 2] = gain_reg;
            end
            `RD_ADR_STATUS: begin
                rd_data[`RD_STAT_FOUND_LSB +: 4] = found;
                rd_data[`RD_STAT_CM50_LSB +: 4] = cm_50ohm_o;
                rd_data[`RD_STAT_STANDBY_BIT] = standby_o;
                rd_data[`RD_STAT_MODE_LSB +: 2] = mode_strap;
                rd_data[`RD_STAT_DETEN_BIT] = det_en;
            end
            `RD_ADR_STRAP: begin
                rd_data[`RD_STRAP_EQ_LSB +: 4] = {eq_hi, eq_lo};
                rd_data[`RD_STRAP_GAIN_LSB +: 2] = gain_strap;
                rd_data[`RD_STRAP_RXDET_LSB +: 2] = rxdet_strap;
                rd_data[`RD_STRAP_ADDR01_LSB +: 7] = slave_addr_ch01_o;
                rd_data[`RD_STRAP_ADDR23_LSB +: 7] = slave_addr_ch23_o;
            end
            default: begin
                rd_data = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (wb_req && !wb_ack_o) begin
            wb_dat_o <= rd_data;
        end
    end

    // control register only writable while a bus master owns configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eq_reg <= `RD_EQ_RESET;
            gain_reg <= `RD_GAIN_RESET;
        end else if (wb_wr && slave_mode && {wb_adr_i[7:2], 2'h0} == `RD_ADR_CTRL) begin
            eq_reg <= wb_dat_i[`RD_CTRL_EQ_LSB +: 4];
            gain_reg <= wb_dat_i[`RD_CTRL_GAIN_LSB +: 2];
        end
    end

    // {hi, lo} is exactly four times hi plus lo
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eq_index_o <= `RD_EQ_RESET;
            flat_gain_o <= `RD_GAIN_RESET;
            ctrl_mode_o <= `RD_STRAP_RESET;
            slave_enable_o <= 1'b0;
        end else begin
            eq_index_o <= strap_mode ? {eq_hi, eq_lo} : eq_reg;
            flat_gain_o <= strap_mode ? gain_strap : gain_reg;
            ctrl_mode_o <= mode_strap;
            slave_enable_o <= slave_mode;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slave_addr_ch01_o <= 7'h00;
            slave_addr_ch23_o <= 7'h01;
        end else begin
            slave_addr_ch01_o <= slave_addr(mode_strap, addr_strap);
            slave_addr_ch23_o <= slave_addr(mode_strap, addr_strap) + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_down_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            pwr_down_q <= power_down_pin_i;
            sel_q <= mux_select_i;
        end
    end

    // power-down release restarts detection; the controller owns the hold time
    always_comb begin
        trig = 4'h0;
        if (det_en && !power_down_pin_i) begin
            if (capture || (pwr_down_q && !power_down_pin_i) || (sel_q != mux_select_i)) begin
                trig = 4'hF;
            end
            if (reg_trig_wr) begin
                trig = trig | wb_dat_i[3:0];
            end
        end
    end

    assign probe_done = (state == DET_PROBE) && (cnt == 20'h0);
    assign newly_found = probe_done ? (detect_probe_o & far_term_sensed_i) : 4'h0;

    // a new trigger wins over a same-cycle probe result
    always_ff @(posedge clk_i) begin
        if (rst_i || power_down_pin_i) begin
            pending <= 4'h0;
            found <= 4'h0;
        end else begin
            pending <= (pending & ~newly_found) | trig;
            found <= (found & ~trig) | (newly_found & ~trig);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || power_down_pin_i || !det_en) begin
            state <= DET_IDLE;
            cnt <= 20'h0;
            detect_probe_o <= 4'h0;
        end else begin
            case (state)
                DET_IDLE: begin
                    if (|pending) begin
                        state <= DET_PROBE;
                        cnt <= 20'(PROBE_CYCLES - 1);
                        detect_probe_o <= pending;
                    end
                end
                DET_PROBE: begin
                    if (cnt == 20'h0) begin
                        detect_probe_o <= 4'h0;
                        if ((pending & ~newly_found) == 4'h0) begin
                            state <= DET_IDLE;
                        end else begin
                            state <= DET_POLL_WAIT;
                            cnt <= 20'(POLL_CYCLES - 1);
                        end
                    end else begin
                        cnt <= cnt - 20'h1;
                    end
                end
                DET_POLL_WAIT: begin
                    if (cnt == 20'h0) begin
                        state <= DET_IDLE;
                    end else begin
                        cnt <= cnt - 20'h1;
                    end
                end
                default: begin
                    state <= DET_IDLE;
                end
            endcase
        end
    end

    // with detection enabled, impedance stays high until a channel proves a far-end termination; with detection off and power-down low all four go to 50 ohm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cm_50ohm_o <= 4'h0;
            channel_reset_o <= 1'b1;
            standby_o <= 1'b0;
        end else begin
            channel_reset_o <= power_down_pin_i;
            standby_o <= power_down_pin_i;
            if (power_down_pin_i) begin
                cm_50ohm_o <= 4'h0;
            end else if (!det_en) begin
                cm_50ohm_o <= 4'hF;
            end else begin
                cm_50ohm_o <= (found & ~trig) | (newly_found & ~trig);
            end
        end
    end

    eq_strap_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        strap_mode |=> eq_index_o == $past({eq_hi, eq_lo}))
        else $error("strap equalizer index wrong");
    eq_reg_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        slave_mode |=> eq_index_o == $past(eq_reg))
        else $error("register equalizer not applied");
    gain_strap_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        strap_mode |=> flat_gain_o == $past(gain_strap))
        else $error("strap gain not applied");
    buffer_imp_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!power_down_pin_i && !det_en) |=> (cm_50ohm_o == 4'hF && state == DET_IDLE))
        else $error("buffer mode not at 50 ohm");
    standby_pd_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        power_down_pin_i |=> (cm_50ohm_o == 4'h0 && channel_reset_o && standby_o
            && detect_probe_o == 4'h0 && pending == 4'h0))
        else $error("power-down did not reset channels");
    powerup_det_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (capture && det_en && !power_down_pin_i) |=> pending == 4'hF)
        else $error("power-up detect not on all channels");
    reg_trig_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_trig_wr && det_en && !power_down_pin_i)
            |=> (pending & $past(wb_dat_i[3:0])) == $past(wb_dat_i[3:0]))
        else $error("register detect not started");
    poll_wait_a: assert property (
        @(posedge clk_i) disable iff (rst_i || power_down_pin_i)
        (probe_done && trig == 4'h0 && (pending & ~newly_found) != 4'h0 && det_en)
            |=> (state == DET_POLL_WAIT && cnt == 20'(POLL_CYCLES - 1)))
        else $error("poll interval not started");
    addr_pair_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mode_strap == 2'h1) |=> (slave_addr_ch01_o == 7'h18 + {4'h0, $past(addr_strap), 1'b0}
            && slave_addr_ch23_o == slave_addr_ch01_o + 7'h01))
        else $error("slave address pair wrong");
    straps_held_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !capture |=> $stable({eq_hi, eq_lo, gain_strap, rxdet_strap}))
        else $error("sampled strap changed after power-up");
    mode_track_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ctrl_mode_o == $past(mode_strap))
        else $error("control mode not tracked");

    powerup_found_c: cover property (
        @(posedge clk_i) disable iff (rst_i) capture ##[1:200] (found == 4'hF));
    poll_retry_c: cover property (
        @(posedge clk_i) disable iff (rst_i) (state == DET_POLL_WAIT) ##1 (state == DET_IDLE));
    reg_detect_c: cover property (
        @(posedge clk_i) disable iff (rst_i) reg_trig_wr ##1 (pending != 4'h0));
endmodule
`default_nettype wire

// ===== rtl/redriver_pkg.sv
// redriver_pkg: shared types of the redriver control logic
// assumes nothing beyond a SystemVerilog compiler
package redriver_pkg;
    typedef logic [1:0] strap_level_t;
    typedef enum {DET_IDLE, DET_PROBE, DET_POLL_WAIT} det_state_t;
endpackage

// ===== verif/far_end_model.sv
// far_end_model: termination of the four far receivers as the probe sees it
// assumes probe_i stays high for a whole probe window; clk_i shared with the block
`timescale 1ns/100ps
`default_nettype none
module far_end_model #(
    parameter int SETTLE = 2
) (
    input wire logic clk_i,
    input wire logic [3:0] probe_i,
    input wire logic [3:0] present_i,
    output logic [3:0] sensed_o
);
    logic [7:0] cnt [4] = '{default: 8'h00};
    logic [3:0] noise = 4'h5;
    // a slow line only shows termination once the probe has settled
    always_ff @(posedge clk_i) begin
        noise <= ~noise;
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= probe_i[i] ? cnt[i] + ((cnt[i] == 8'hFF) ? 8'h00 : 8'h01) : 8'h00;
        end
    end
    // outside a probe the sense line wanders, so a stale sample is caught
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sensed_o[i] = probe_i[i] ? (present_i[i] && cnt[i] >= 8'(SETTLE)) : noise[i];
        end
    end
endmodule
`default_nettype wire

// ===== verif/redriver_strap_config_rx_detect_bench.sv
// redriver_strap_config_rx_detect_bench: self-checking bench of straps, mode and detect
// assumes redriver_ctrl and far_end_model compiled first; 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module redriver_strap_config_rx_detect_bench;
    import redriver_pkg::*;
    localparam int POLL = 20;
    localparam int PWR_DOWN_HOLD = 20000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pwr_down = 1'b0, mux = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, sensed, present = 4'h0, eq_index, probe, cm;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [2:0] eql = 3'h0, eqh = 3'h0, gain = 3'h0, mode = 3'h0, addr = 3'h0, det = 3'h0;
    logic wb_ack_o, slave_en, ch_rst, standby;
    strap_level_t flat_gain, ctrl_mode;
    logic [6:0] a01, a23;
    int miscompares = 0;
    int n_checks = 0;

    redriver_ctrl #(.POLL_CYCLES(POLL)) redriver_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eq_strap_low_i(eql),
        .eq_strap_high_i(eqh), .gain_strap_i(gain), .mode_strap_i(mode),
        .addr_strap_i(addr), .far_termination_detect_strap_i(det), .power_down_pin_i(pwr_down),
        .mux_select_i(mux), .far_term_sensed_i(sensed), .eq_index_o(eq_index),
        .flat_gain_o(flat_gain), .ctrl_mode_o(ctrl_mode), .slave_enable_o(slave_en),
        .slave_addr_ch01_o(a01), .slave_addr_ch23_o(a23), .detect_probe_o(probe),
        .cm_50ohm_o(cm), .channel_reset_o(ch_rst), .standby_o(standby));

    // slow answer, settles well inside the probe window
    far_end_model #(.SETTLE(60)) far_end_model_i (
        .clk_i(clk_i), .probe_i(probe), .present_i(present), .sensed_o(sensed));

    always #5 clk_i = ~clk_i;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic [2:0] th(input int l);
        return 3'(7 >> (3 - l));
    endfunction

    // classic single cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20) begin
            chk(32'(wb_ack_o), 32'h1);
            stop_test();
        end
        @(posedge clk_i);
    endtask

    task automatic wait_for(input bit use_cm, input logic [3:0] exp, input int bound);
        logic [3:0] cur;
        for (int i = 0; i < bound; i++) begin
            @(posedge clk_i);
            cur = use_cm ? cm : probe;
            if (cur === exp) return;
        end
        chk(32'(cur), 32'(exp));
        stop_test();
    endtask

    // straps must be steady across the power-up edge
    task automatic power_up(input int eh, input int el, input int g, input int m,
                            input int a, input int d);
        rst_i <= 1'b1;
        pwr_down <= 1'b0;
        eqh <= th(eh);
        eql <= th(el);
        gain <= th(g);
        mode <= th(m);
        addr <= th(a);
        det <= th(d);
        tick(10);
        rst_i <= 1'b0;
        tick(4);
    endtask

    task automatic test_straps;
        logic [31:0] rd;
        for (int k = 0; k < 4; k++) begin
            power_up(k, 3 - k, k, 0, k, 0);
            chk(eq_index, 3 * k + 3);
            chk({ctrl_mode, flat_gain}, k);
            chk({slave_en, probe, cm}, 9'h00F);
            pwr_down <= 1'b1;
            tick(3);
            chk({standby, ch_rst, cm}, 6'h30);
            pwr_down <= 1'b0;
            tick(3);
            chk({probe, cm}, 8'h0F);
            eqh <= th(3 - k);
            gain <= th(3 - k);
            det <= th(3);
            tick(4);
            chk({probe, flat_gain, eq_index}, (k << 4) | (3 * k + 3));
            mode <= th(1);
            tick(4);
            chk({ctrl_mode, slave_en}, 3'h3);
            chk({a01, a23}, {7'(24 + 2 * k), 7'(25 + 2 * k)});
            mode <= th(2);
            tick(4);
            chk({slave_en, a01, a23}, {1'b1, 7'(32 + 2 * k), 7'(33 + 2 * k)});
            wb(1'b1, 8'h00, 32'(((k ^ 1) << 4) | (15 - k)), 4'hF, rd);
            tick(3);
            chk({flat_gain, eq_index}, ((k ^ 1) << 4) | (15 - k));
            mode <= th(0);
            tick(4);
            chk({flat_gain, eq_index}, (k << 4) | (3 * k + 3));
            // level 3 is not strap control, so the straps must not steer the equalizer
            mode <= th(3);
            tick(4);
            chk({slave_en, flat_gain, eq_index}, ((k ^ 1) << 4) | (15 - k));
        end
        $display("test straps done");
    endtask

    task automatic test_poll;
        present <= 4'h5;
        power_up(0, 0, 3, 0, 0, 3);
        wait_for(0, 4'hF, 5);
        chk(cm, 4'h0);
        wait_for(1, 4'h5, 120);
        wait_for(0, 4'hA, POLL + 20);
        chk(cm, 4'h5);
        present <= 4'hF;
        wait_for(1, 4'hF, POLL + 250);
        $display("test poll done");
    endtask

    task automatic test_pd;
        pwr_down <= 1'b1;
        tick(3);
        chk({standby, ch_rst, probe, cm}, 10'h300);
        tick(PWR_DOWN_HOLD);
        pwr_down <= 1'b0;
        wait_for(0, 4'hF, 10);
        wait_for(0, 4'h0, 120);
        tick(2);
        chk({standby, ch_rst, cm}, 6'h0F);
        mux <= ~mux;
        wait_for(0, 4'hF, 10);
        wait_for(1, 4'hF, 120);
        $display("test power down done");
    endtask

    task automatic test_reg;
        logic [31:0] rd;
        mode <= th(2);
        tick(4);
        wb(1'b1, 8'h04, 32'h2, 4'hF, rd);
        wait_for(0, 4'h2, 10);
        wait_for(0, 4'h0, 120);
        tick(2);
        chk(cm, 4'hF);
        wb(1'b1, 8'h00, 32'h5, 4'hE, rd);
        tick(3);
        chk(eq_index, 4'h0);
        wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
        chk(rd, 32'h0000_0CFF);
        wb(1'b0, 8'h0C, 32'h0, 4'hF, rd);
        chk(rd, 32'h0021_20F0);
        wb(1'b0, 8'h10, 32'h0, 4'hF, rd);
        chk(rd, 32'h0);
        $display("test register detect done");
    endtask

    initial begin
        test_straps();
        test_poll();
        test_pd();
        test_reg();
        stop_test();
    end
endmodule
`default_nettype wire
